/* File: rtl/omc_map.svh */
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OMC_CTRL_OFS 8'h00
`define OMC_FLAGS_OFS 8'h04
`define OMC_STATUS_OFS 8'h08
`define OMC_WTIMER_OFS 8'h0c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define OMC_CTRL_DISP_BIT 0
`define OMC_CTRL_SLEEP_BIT 1
`define OMC_CTRL_ADC_BIT 2
`define OMC_CTRL_CE_BIT 3
`define OMC_CTRL_DIV_LSB 4
`define OMC_CTRL_DIV_MSB 6
`define OMC_FLAG_BUTTON_BIT 4
`define OMC_FLAG_TIMER_BIT 5
`define OMC_FLAG_LOCK_BIT 6
`define OMC_FLAG_LOSS_BIT 7
`define OMC_STAT_MODE_LSB 0
`define OMC_STAT_MODE_MSB 1
`define OMC_STAT_PLL_BIT 2
`define OMC_STAT_SUPPLY_BIT 3
`define OMC_STAT_BAT_BIT 4
`define OMC_STAT_WAKE_BIT 5
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define OMC_CTRL_RESET 7'h00
`define OMC_FLAGS_RESET 4'h0
`define OMC_WTIMER_RESET 16'h0100
`define OMC_CLK_HZ 40000000
`define OMC_SLOW_TICK_HZ 32
`define OMC_SLOW_TICK_CYCLES (`OMC_CLK_HZ / `OMC_SLOW_TICK_HZ)
`endif

/* File: rtl/omc_pkg.sv */
package omc_pkg;
   typedef enum logic [1:0] {
      OMC_MISSION,
      OMC_BROWNOUT,
      OMC_DISPLAY,
      OMC_SLEEP
   } omc_mode_t;
endpackage

/* File: rtl/omc_sync.sv */
`timescale 1ns/1ps
module omc_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         meta_q <= '0;
         q_out <= '0;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end
endmodule // omc_sync

/* File: rtl/omc_button.sv */
`timescale 1ns/1ps
module omc_button (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic tick_in,
   input wire logic btn_in,
   input wire logic armed_in,
   output logic rise_out
);
   logic level_q;
   logic pend_q;
   wire differs = (btn_in != level_q);

   // A new level must hold over two slow ticks, so short noise is rejected
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         level_q <= 1'b0;
         pend_q <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         rise_out <= 1'b0;
         if (tick_in) begin
            if (!differs) begin
               pend_q <= 1'b0;
            end else if (pend_q) begin
               level_q <= btn_in;
               pend_q <= 1'b0;
               rise_out <= btn_in & armed_in;
            end else begin
               pend_q <= 1'b1;
            end
         end
      end
   end
endmodule // omc_button

/* File: rtl/omc_top.sv */
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "omc_map.svh"
// Behaviour
// R1 - Mission mode only with supply present and PLL stable; only there metering runs.
// R2 - Supply fault or wake under battery leads automatically into battery-run mode.
// R3 - In battery-run, display-only or sleep request bit forces that mode, processor off.
// R4 - Leaving mission for battery-run sets the PLL-loss flag, bit 7.
// R5 - Returning to mission with PLL stable sets the PLL-lock flag, bit 6.
// R6 - Push button going high sets the button wake flag, bit 4.
// R7 - Wake timer expiry sets the timer wake flag, bit 5.
// R8 - Display-only and sleep exit only on timer, button or supply return.
// R9 - On battery, margin loss enters sleep; stays there when margin recovers.
// R10 - Supply return moves any battery mode to mission once PLL settled.
// R11 - Battery-run clocks the processor from the crystal, not the PLL.
// R12 - Processor clock divider setting is kept across battery-run entry and exit.
// R13 - While PLL unlocked, converter and compute-engine enables are forced low.
// R14 - PLL lock falling clears compute-engine program counter and halts filtering.
// R15 - Battery-run keeps debug, serial, memory and display alive; metering stays off.
// R16 - Auxiliary supply output stays enabled during battery-run mode.
// R17 - Firmware should enter sleep when battery functions are not needed.
// R18 - Mission entry from display-only or sleep shows configuration at reset values.
// R19 - Supply loss without battery drops wake and enters sleep.
// R20 - Operating mode is held in a state register on the single clock.
module omc_top #(
   parameter int SLOW_TICK_CYCLES = `OMC_SLOW_TICK_CYCLES,
   parameter int DIV_W = 3
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic supply_sense_input_in,
   input wire logic pll_locked_in,
   input wire logic battery_margin_good_in,
   input wire logic push_button_input_in,
   output logic [1:0] mode_out,
   output logic wake_out,
   output logic processor_enable_out,
   output logic processor_clk_from_pll_out,
   output logic [DIV_W-1:0] processor_clock_divider_out,
   output logic adc_enable_out,
   output logic ce_enable_out,
   output logic ce_pc_clear_out,
   output logic filter_halt_out,
   output logic metering_active_out,
   output logic peripherals_active_out,
   output logic aux_supply_output_out,
   output logic config_reset_out,
   output logic [3:0] flags_out
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic supply_s;
   logic pll_s;
   logic bat_s;
   logic btn_s;

   omc_sync #(.W(4)) u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .d_in({supply_sense_input_in, pll_locked_in, battery_margin_good_in, push_button_input_in}),
      .q_out({supply_s, pll_s, bat_s, btn_s})
   );

   // ----------------------------------------
   // Slow tick divider and push button
   // ----------------------------------------
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic btn_rise;
   logic timer_exp;
   logic [3:0] flags_q;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 32'(SLOW_TICK_CYCLES - 1)) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end

   // Further presses are ignored until firmware clears the button flag
   omc_button u_button (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .tick_in(tick_q),
      .btn_in(btn_s),
      .armed_in(~flags_q[`OMC_FLAG_BUTTON_BIT - 4]),
      .rise_out(btn_rise)
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire access = psel_in & penable_in;
   wire sel_ctrl = (paddr_in == `OMC_CTRL_OFS);
   wire sel_flags = (paddr_in == `OMC_FLAGS_OFS);
   wire sel_stat = (paddr_in == `OMC_STATUS_OFS);
   wire sel_wtim = (paddr_in == `OMC_WTIMER_OFS);
   wire mapped = sel_ctrl | sel_flags | sel_stat | sel_wtim;
   wire wr_done = access & pwrite_in & pready_out & mapped;
   wire wr_ctrl = wr_done & sel_ctrl;
   wire wr_flags = wr_done & sel_flags;
   wire wr_wtim = wr_done & sel_wtim;

   // ----------------------------------------
   // Mode state machine
   // ----------------------------------------
   omc_pkg::omc_mode_t state_q;
   omc_pkg::omc_mode_t state_d;
   logic [6:0] ctrl_q;
   logic [15:0] wtim_q;
   logic [15:0] wcnt_q;
   logic pll_d1_q;

   wire sys_ok = supply_s & pll_s;
   wire wake_evt = btn_rise | timer_exp;
   wire in_low = (state_q == omc_pkg::OMC_DISPLAY) | (state_q == omc_pkg::OMC_SLEEP);

   always_comb begin
      state_d = state_q;
      case (state_q)
         omc_pkg::OMC_MISSION: begin
            if (!sys_ok) begin
               state_d = bat_s ? omc_pkg::OMC_BROWNOUT : omc_pkg::OMC_SLEEP; // [R1] [R2] [R19]
            end
         end
         omc_pkg::OMC_BROWNOUT: begin
            if (sys_ok) begin
               state_d = omc_pkg::OMC_MISSION; // [R10]
            end else if (!bat_s) begin
               state_d = omc_pkg::OMC_SLEEP; // [R9]
            end else if (ctrl_q[`OMC_CTRL_SLEEP_BIT]) begin
               state_d = omc_pkg::OMC_SLEEP; // [R3]
            end else if (ctrl_q[`OMC_CTRL_DISP_BIT]) begin
               state_d = omc_pkg::OMC_DISPLAY; // [R3]
            end
         end
         omc_pkg::OMC_DISPLAY, omc_pkg::OMC_SLEEP: begin
            if (sys_ok) begin
               state_d = omc_pkg::OMC_MISSION; // [R10]
            end else if (wake_evt && bat_s) begin
               state_d = omc_pkg::OMC_BROWNOUT; // [R2] [R8]
            end
         end
         default: begin
            state_d = omc_pkg::OMC_SLEEP;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= omc_pkg::OMC_SLEEP;
      end else begin
         state_q <= state_d; // [R20]
      end
   end

   // ----------------------------------------
   // Control and wake timer registers
   // ----------------------------------------
   // Wake is low in display-only and sleep, so configuration is held at reset
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || in_low) begin
         ctrl_q <= `OMC_CTRL_RESET; // [R18]
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata_in[6:0]; // [R12]
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wtim_q <= `OMC_WTIMER_RESET;
      end else if (wr_wtim) begin
         wtim_q <= pwdata_in[15:0];
      end
   end

   // Timer counts slow ticks only while parked in a low-power mode
   assign timer_exp = in_low & tick_q & (wcnt_q == 16'h0001);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !in_low) begin
         wcnt_q <= wtim_q;
      end else if (tick_q && wcnt_q != 16'h0000) begin
         wcnt_q <= wcnt_q - 16'h0001;
      end
   end

   // ----------------------------------------
   // Event flags, write one to clear, set wins
   // ----------------------------------------
   wire set_loss = (state_q == omc_pkg::OMC_MISSION) & (state_d == omc_pkg::OMC_BROWNOUT);
   wire set_lock = (state_q != omc_pkg::OMC_MISSION) & (state_d == omc_pkg::OMC_MISSION);
   wire [3:0] flag_set = {set_loss, set_lock, timer_exp, btn_rise};
   wire [3:0] flag_clr = wr_flags ? pwdata_in[7:4] : 4'h0;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         flags_q <= `OMC_FLAGS_RESET;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set; // [R4] [R5] [R6] [R7]
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   wire next_mission = (state_d == omc_pkg::OMC_MISSION);
   wire next_brown = (state_d == omc_pkg::OMC_BROWNOUT);
   wire from_low = in_low & next_mission;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pll_d1_q <= 1'b0;
         mode_out <= 2'h3;
         wake_out <= 1'b0;
         processor_enable_out <= 1'b0;
         processor_clk_from_pll_out <= 1'b0;
         processor_clock_divider_out <= '0;
         adc_enable_out <= 1'b0;
         ce_enable_out <= 1'b0;
         ce_pc_clear_out <= 1'b0;
         filter_halt_out <= 1'b1;
         metering_active_out <= 1'b0;
         peripherals_active_out <= 1'b0;
         aux_supply_output_out <= 1'b0;
         config_reset_out <= 1'b0;
         flags_out <= 4'h0;
      end else begin
         pll_d1_q <= pll_s;
         mode_out <= state_d;
         wake_out <= next_mission | next_brown; // [R19]
         processor_enable_out <= next_mission | next_brown; // [R3]
         processor_clk_from_pll_out <= next_mission; // [R11]
         processor_clock_divider_out <= ctrl_q[`OMC_CTRL_DIV_MSB:`OMC_CTRL_DIV_LSB]; // [R12]
         adc_enable_out <= ctrl_q[`OMC_CTRL_ADC_BIT] & pll_s; // [R13]
         ce_enable_out <= ctrl_q[`OMC_CTRL_CE_BIT] & pll_s; // [R13]
         ce_pc_clear_out <= pll_d1_q & ~pll_s; // [R14]
         filter_halt_out <= ~pll_s; // [R14]
         metering_active_out <= next_mission & pll_s; // [R1] [R15]
         peripherals_active_out <= next_mission | next_brown; // [R15]
         aux_supply_output_out <= next_mission | next_brown; // [R16]
         config_reset_out <= from_low; // [R18]
         flags_out <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------
   // APB slave, one wait state
   // ----------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux[6:0] = ctrl_q;
      end else if (sel_flags) begin
         rd_mux[7:4] = flags_q;
      end else if (sel_stat) begin
         rd_mux[`OMC_STAT_MODE_MSB:`OMC_STAT_MODE_LSB] = state_q;
         rd_mux[`OMC_STAT_PLL_BIT] = pll_s;
         rd_mux[`OMC_STAT_SUPPLY_BIT] = supply_s;
         rd_mux[`OMC_STAT_BAT_BIT] = bat_s;
         rd_mux[`OMC_STAT_WAKE_BIT] = wake_out;
      end else if (sel_wtim) begin
         rd_mux[15:0] = wtim_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         pready_out <= access & ~pready_out;
         pslverr_out <= access & ~pready_out & ~mapped;
         if (access && !pready_out && !pwrite_in) begin
            prdata_out <= rd_mux;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_mission_exit;
      (state_q == omc_pkg::OMC_MISSION) ##1 (state_q == omc_pkg::OMC_BROWNOUT);
   endsequence

   sequence s_mission_entry;
      (state_q != omc_pkg::OMC_MISSION) ##1 (state_q == omc_pkg::OMC_MISSION);
   endsequence

   a_mission_needs_power: assert property (!sys_ok |=> state_q != omc_pkg::OMC_MISSION) // [R1]
      else $error("mission held without supply and lock");
   a_fault_to_brownout: assert property ( // [R2]
      (state_q == omc_pkg::OMC_MISSION) && !supply_s && bat_s |=> state_q == omc_pkg::OMC_BROWNOUT)
      else $error("supply fault did not enter battery-run");
   a_request_forces_mode: assert property ( // [R3]
      (state_q == omc_pkg::OMC_BROWNOUT) && !sys_ok && bat_s && ctrl_q[`OMC_CTRL_SLEEP_BIT]
      |=> (state_q == omc_pkg::OMC_SLEEP) && !processor_enable_out)
      else $error("sleep request not taken");
   a_loss_flag_set: assert property (s_mission_exit |-> flags_q[3]) // [R4]
      else $error("pll loss flag missing");
   a_lock_flag_set: assert property (s_mission_entry |-> flags_q[2]) // [R5]
      else $error("pll lock flag missing");
   a_button_flag_set: assert property (btn_rise |=> flags_q[0] && flags_out[0]) // [R6]
      else $error("button flag missing");
   a_timer_flag_set: assert property (timer_exp |=> flags_q[1]) // [R7]
      else $error("timer flag missing");
   a_low_mode_holds: assert property (in_low && !wake_evt && !sys_ok |=> $stable(state_q)) // [R8]
      else $error("low power mode left without cause");
   // Wake drops on the same edge as the state, so both are checked together
   a_margin_to_sleep: assert property ( // [R9] [R19]
      (state_q == omc_pkg::OMC_BROWNOUT) && !sys_ok && !bat_s |=> (state_q == omc_pkg::OMC_SLEEP) && !wake_out)
      else $error("margin loss did not enter sleep");
   a_enables_gated: assert property (!pll_s |=> !adc_enable_out && !ce_enable_out) // [R13]
      else $error("enables not forced low");
   a_pc_clear_pulse: assert property ($fell(pll_s) |=> ce_pc_clear_out ##1 !ce_pc_clear_out) // [R14]
      else $error("program counter clear pulse wrong");
   a_aux_in_brownout: assert property ( // [R11] [R16]
      (state_q == omc_pkg::OMC_BROWNOUT) |-> aux_supply_output_out && !processor_clk_from_pll_out)
      else $error("battery-run outputs wrong");
   a_divider_kept: assert property (s_mission_exit |-> $stable(ctrl_q[6:4])) // [R12]
      else $error("divider changed on battery-run entry");
endmodule // omc_top

/* File: tb/omc_monitor_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Supply, PLL and battery monitors
// ----------------------------------------
module omc_monitor_model #(
   parameter int LOCK_CYC = 12
) (
   input wire logic clk_in,
   input wire logic supply_on_in,
   input wire logic battery_ok_in,
   output logic supply_sense_out,
   output logic pll_locked_out,
   output logic battery_margin_good_out
);
   int cnt;
   initial begin
      cnt = 0;
      supply_sense_out = 1'b0;
      pll_locked_out = 1'b0;
      battery_margin_good_out = 1'b0;
   end
   // PLL needs supply steady for a while before lock, and drops with supply at once
   always @(posedge clk_in) begin
      supply_sense_out <= supply_on_in;
      battery_margin_good_out <= battery_ok_in;
      if (!supply_on_in)
         cnt <= 0;
      else if (cnt < LOCK_CYC)
         cnt <= cnt + 1;
      pll_locked_out <= supply_on_in && (cnt == LOCK_CYC);
   end
endmodule // omc_monitor_model

/* File: tb/operating_mode_controller_tb.sv */
`timescale 1ns/1ps
module operating_mode_controller_tb;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic supply_on = 1'b1, battery_margin_good = 1'b1, btn = 1'b0;
   logic sense, pll, margin, pready, pslverr, err;
   logic [31:0] prdata, rd;
   logic [1:0] mode;
   logic wake, pen, pclk, adc, ce, clr, halt, met, per, aux, cfg;
   logic [2:0] div, rdiv;
   logic [3:0] flags;
   logic [3:0] exp_flags = 4'h0;
   int errors = 0, num_checks = 0, cycles = 0, n_clr = 0, n_cfg = 0, clr0, cfg0;

   always #12.5 clk_in = ~clk_in;

   // Hang guard; a full run takes a few hundred cycles
   always @(posedge clk_in) begin
      cycles++;
      if (clr === 1'b1) n_clr++;
      if (cfg === 1'b1) n_cfg++;
      if (cycles > 20000) begin
         errors++;
         end_sim();
      end
   end

   omc_monitor_model u_mon (.clk_in(clk_in), .supply_on_in(supply_on), .battery_ok_in(battery_margin_good),
      .supply_sense_out(sense), .pll_locked_out(pll), .battery_margin_good_out(margin));

   omc_top #(.SLOW_TICK_CYCLES(8)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .supply_sense_input_in(sense),
      .pll_locked_in(pll), .battery_margin_good_in(margin), .push_button_input_in(btn),
      .mode_out(mode), .wake_out(wake), .processor_enable_out(pen), .processor_clk_from_pll_out(pclk),
      .processor_clock_divider_out(div), .adc_enable_out(adc), .ce_enable_out(ce),
      .ce_pc_clear_out(clr), .filter_halt_out(halt), .metering_active_out(met),
      .peripherals_active_out(per), .aux_supply_output_out(aux), .config_reset_out(cfg),
      .flags_out(flags));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (mode !== m && n < 300);
      chk("mode", m, mode);
      chk("wake", m <= 1, wake);
      chk("processor_enable", m <= 1, pen);
      chk("clk_from_pll", m == 0, pclk);
      chk("aux_supply", m <= 1, aux);
      chk("peripherals", m <= 1, per);
      chk("metering", m == 0, met);
      chk("filter_halt", m != 0, halt);
   endtask

   // Read flags against the model, then clear them all
   task flags_chk();
      apb(1'b0, 8'h04, 32'h0);
      chk("flags_reg", exp_flags, rd[7:4]);
      chk("flags_out", exp_flags, flags);
      apb(1'b1, 8'h04, 32'hf0);
      exp_flags = 4'h0;
   endtask

   task end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h02ea7b3b));
      repeat (19) @(posedge clk_in);
      @(negedge clk_in);
      chk("reset_mode", 3, mode);
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      wait_mode(0);
      exp_flags = 4'b0100;
      flags_chk();
      apb(1'b0, 8'h0c, 32'h0);
      chk("wtimer_reset", 32'h100, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 1, err);
      chk("unmapped_data", 0, rd);
      rdiv = $urandom_range(7, 1);
      apb(1'b1, 8'h00, {25'h0, rdiv, 4'hc});
      repeat (3) @(negedge clk_in);
      chk("adc_en", 1, adc);
      chk("ce_en", 1, ce);
      clr0 = n_clr;
      @(posedge clk_in);
      supply_on <= 1'b0;
      wait_mode(1);
      chk("divider", rdiv, div);
      exp_flags = 4'b1000;
      flags_chk();
      chk("pc_clear_pulses", clr0 + 1, n_clr);
      // Firmware enables are overridden while unlocked
      apb(1'b1, 8'h00, {25'h0, rdiv, 4'hc});
      repeat (3) @(negedge clk_in);
      chk("adc_forced", 0, adc);
      chk("ce_forced", 0, ce);
      // Straight return from battery-run keeps configuration
      cfg0 = n_cfg;
      @(posedge clk_in);
      supply_on <= 1'b1;
      wait_mode(0);
      repeat (2) @(negedge clk_in);
      chk("divider_back", rdiv, div);
      chk("no_config_pulse", cfg0, n_cfg);
      exp_flags = 4'b0100;
      flags_chk();
      @(posedge clk_in);
      supply_on <= 1'b0;
      wait_mode(1);
      exp_flags = 4'b1000;
      flags_chk();
      apb(1'b1, 8'h0c, 32'h2);
      apb(1'b1, 8'h00, 32'h2);
      wait_mode(3);
      wait_mode(1);
      exp_flags = 4'b0010;
      flags_chk();
      apb(1'b1, 8'h0c, 32'hffff);
      apb(1'b1, 8'h00, 32'h1);
      wait_mode(2);
      repeat (100) @(negedge clk_in);
      chk("display_stays", 2, mode);
      @(posedge clk_in);
      btn <= 1'b1;
      repeat ($urandom_range(60, 30)) @(posedge clk_in);
      btn <= 1'b0;
      wait_mode(1);
      exp_flags = 4'b0001;
      flags_chk();
      @(posedge clk_in);
      battery_margin_good <= 1'b0;
      wait_mode(3);
      @(posedge clk_in);
      battery_margin_good <= 1'b1;
      repeat (100) @(negedge clk_in);
      chk("sleep_stays", 3, mode);
      cfg0 = n_cfg;
      @(posedge clk_in);
      supply_on <= 1'b1;
      wait_mode(0);
      repeat (2) @(negedge clk_in);
      chk("config_pulses", cfg0 + 1, n_cfg);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl_after_wake", 0, rd);
      exp_flags = 4'b0100;
      flags_chk();
      apb(1'b0, 8'h08, 32'h0);
      chk("status_word", 32'h0000_003c, rd);
      @(posedge clk_in);
      battery_margin_good <= 1'b0;
      @(posedge clk_in);
      supply_on <= 1'b0;
      wait_mode(3);
      flags_chk();
      end_sim();
   end
endmodule // operating_mode_controller_tb
